// file: flash_memory_controller_tb.sv
// Purpose: Self-checking bench for the flash memory controller.
// Assumes: Short sim timings of 3, 5 and 7 microseconds.
// Notes:   Timebase toggles every microsecond, unrelated to the clock.
`timescale 1ns/1ns
`include "fmc_consts.svh"
module flash_memory_controller_tb;
  import fmc_pkg::*;
  logic core_clk = 0, rst = 1, tb_toggle = 0, sram_at_zero = 0;
  logic cpu_req = 0, mmr_wr = 0, mmr_rd = 0, cpu_hit, cpu_stall, cpu_ack_ff;
  logic [31:0] cpu_addr = 0, mmr_addr = 0, mmr_wdata = 0, rv, t0;
  logic [31:0] cpu_rdata_ff, mmr_rdata_ff, arr_pa_ff, arr_pd_ff;
  logic [1:0] cpu_size = 0, arr_prog_ff, arr_erase_ff, arr_mass_ff;
  logic [15:0] arr_ra0, arr_ra1, arr_ca;
  fmc_hw_t arr_rd0, arr_rd1, arr_crd;
  logic [7:0] shadow = 8'hFF; // Stored protection for both blocks.
  logic [23:0] sig;
  int mismatches = 0, n_checks = 0;
  always #10 core_clk = ~core_clk;
  always #1000 tb_toggle = ~tb_toggle;
  fmc_flash_ctrl #(.PROG_US(3), .ERASE_US(5), .MASS_US(7)) dut (
    .core_clk(core_clk), .rst(rst), .tb_toggle(tb_toggle),
    .sram_at_zero(sram_at_zero), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .cpu_size(cpu_size), .cpu_hit(cpu_hit), .cpu_stall(cpu_stall),
    .cpu_ack_ff(cpu_ack_ff), .cpu_rdata_ff(cpu_rdata_ff), .mmr_wr(mmr_wr),
    .mmr_rd(mmr_rd), .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata),
    .mmr_rdata_ff(mmr_rdata_ff), .arr_ra0(arr_ra0), .arr_rd0(arr_rd0),
    .arr_ra1(arr_ra1), .arr_rd1(arr_rd1), .arr_ca(arr_ca), .arr_crd(arr_crd),
    .arr_prog_ff(arr_prog_ff), .arr_erase_ff(arr_erase_ff),
    .arr_mass_ff(arr_mass_ff), .arr_pa_ff(arr_pa_ff), .arr_pd_ff(arr_pd_ff),
    .prot_shadow0(shadow), .prot_shadow1(shadow));
  fmc_array_model u_arr (.core_clk(core_clk), .arr_ra0(arr_ra0),
    .arr_rd0(arr_rd0), .arr_ra1(arr_ra1), .arr_rd1(arr_rd1),
    .arr_ca(arr_ca), .arr_crd(arr_crd), .arr_prog_ff(arr_prog_ff),
    .arr_erase_ff(arr_erase_ff), .arr_mass_ff(arr_mass_ff),
    .arr_pa_ff(arr_pa_ff), .arr_pd_ff(arr_pd_ff));
  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One register access: strobe for one cycle, read data the next.
  task automatic acc(input logic w, input logic b, input logic [6:0] off,
                     input logic [31:0] d);
    @(posedge core_clk) #1;
    mmr_wr = w;
    mmr_rd = !w;
    mmr_addr = {`FMC_MMR_PAGE, b, off};
    mmr_wdata = d;
    @(posedge core_clk) #1;
    mmr_wr = 0;
    mmr_rd = 0;
    rv = mmr_rdata_ff;
  endtask : acc
  // Load address and data, then write the command.
  task automatic cmd(input logic b, input logic [15:0] a,
                     input logic [15:0] d, input logic [7:0] c);
    acc(1, b, `FMC_OFF_ADR, a);
    acc(1, b, `FMC_OFF_DAT, d);
    acc(1, b, `FMC_OFF_CON, c);
    t0 = $time;
  endtask : cmd
  // Poll the status until done, under a bound.
  task automatic wait_done(input logic b);
    rv = 0;
    for (int i = 0; i < 3000 && rv[`FMC_STA_DONE] !== 1'b1; i++) begin
      acc(0, b, `FMC_OFF_STA, 0);
    end
    t0 = $time - t0;
  endtask : wait_done
  // Core read, held while stalled; data is checked by the caller.
  task automatic fetch(input logic [31:0] a, input logic [1:0] sz);
    @(posedge core_clk) #1;
    cpu_req = 1;
    cpu_addr = a;
    cpu_size = sz;
    for (int i = 0; i < 9000 && cpu_stall !== 1'b0; i++) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    cpu_req = 0;
    chk({31'b0, cpu_ack_ff}, 1);
    rv = cpu_rdata_ff;
  endtask : fetch
  // Print the counts and the verdict, then stop.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst = 0;
    acc(0, 0, `FMC_OFF_CON, 0); chk(rv, 32'h07);
    acc(0, 1, `FMC_OFF_STA, 0); chk(rv, 0);
    fetch(32'h80004, 2); chk(rv, 32'hFFFFFFFF);
    fetch(32'h4, 2); chk(rv, 32'hFFFFFFFF);
    sram_at_zero = 1;
    #1 chk({31'b0, cpu_hit}, 0);
    sram_at_zero = 0;
    cmd(1, 16'h10, 16'h1234, `FMC_CMD_PROG);
    acc(0, 1, `FMC_OFF_STA, 0); chk(rv, 32'h08);
    acc(1, 1, `FMC_OFF_MOD, 32'h08);
    acc(1, 0, `FMC_OFF_MOD, 32'h08);
    cpu_req = 1;
    cpu_addr = 32'h80010;
    cmd(1, 16'h10, 16'h1234, `FMC_CMD_PROG);
    chk({31'b0, cpu_stall}, 1);
    repeat (2) @(posedge core_clk);
    #1 cpu_addr = 32'h90000;
    #1 chk({31'b0, cpu_stall}, 0);
    cpu_req = 0;
    acc(0, 1, `FMC_OFF_STA, 0); chk(rv, 32'h04);
    acc(1, 1, `FMC_OFF_CON, `FMC_CMD_READ);
    wait_done(1); chk(rv, 32'h09);
    chk({31'b0, t0 > 2000 && t0 < 3300}, 1);
    fetch(32'h80011, 0); chk(rv, 32'h12);
    fetch(32'h80010, 1); chk(rv, 32'h1234);
    fetch(32'h80010, 2); chk(rv, 32'hFFFF1234);
    cmd(1, 16'h10, 0, `FMC_CMD_READ);
    wait_done(1);
    acc(0, 1, `FMC_OFF_DAT, 0); chk(rv, 32'h1234);
    cmd(1, 16'h10, 16'h1234, `FMC_CMD_VFY);
    wait_done(1); chk(rv, 32'h01);
    cmd(1, 16'h10, 16'h1235, `FMC_CMD_VFY);
    wait_done(1); chk(rv, 32'h03);
    cmd(1, 16'h200, 16'hA55A, `FMC_CMD_PROG);
    wait_done(1);
    cmd(1, 16'h10, 0, `FMC_CMD_ERASE);
    wait_done(1); chk({31'b0, t0 > 4000 && t0 < 5300}, 1);
    fetch(32'h80010, 2); chk(rv, 32'hFFFFFFFF);
    fetch(32'h80200, 1); chk(rv, 32'hA55A);
    cmd(0, 16'h7800, 0, `FMC_CMD_PROG);
    acc(0, 0, `FMC_OFF_STA, 0); chk(rv, 32'h08);
    fetch(32'h97800, 1); chk(rv, 32'hFFFF);
    cmd(0, 16'h4, 16'hBEEF, `FMC_CMD_EWR);
    wait_done(0);
    fetch(32'h90004, 1); chk(rv, 32'hBEEF);
    cmd(1, 0, 0, `FMC_CMD_MASS);
    wait_done(1);
    fetch(32'h80200, 1); chk(rv, 32'hFFFF);
    cmd(1, 16'h200, 0, `FMC_CMD_SIGN);
    wait_done(1);
    sig = 0;
    for (int i = 0; i < 256; i++) sig = {sig[22:0], sig[23]} ^ 24'hFFFF;
    acc(0, 1, `FMC_OFF_SIGN, 0); chk(rv, {8'h00, sig});
    shadow = 8'h3C;
    rst = 1;
    repeat (4) @(posedge core_clk);
    #1 rst = 0;
    acc(0, 0, `FMC_OFF_HIDE, 0); chk(rv, 32'h3C);
    acc(0, 0, `FMC_OFF_PRO, 0); chk(rv, 32'h3C);
    acc(1, 0, `FMC_OFF_HIDE, 0);
    acc(0, 0, `FMC_OFF_HIDE, 0); chk(rv, 32'h3C);
    acc(1, 0, `FMC_OFF_HIDE, {`FMC_HIDE_KEY, 8'h11});
    acc(0, 0, `FMC_OFF_HIDE, 0); chk(rv, 32'h11);
    complete_run();
  end
  // Cut a hang short well beyond the expected run length.
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule : flash_memory_controller_tb

// file: fmc_array_model.sv
// Purpose: Behavioural half-word flash array behind the controller.
// Assumes: Block 1 indexes 0x0000-0x7FFF, block 0 0x8000-0xBFFF.
// Notes:   Programming only clears bits, as real cells do.
`timescale 1ns/1ns
module fmc_array_model (
  input wire logic core_clk, // Clock.
  input wire logic [15:0] arr_ra0, // Fetch index low.
  output fmc_pkg::fmc_hw_t arr_rd0, // Fetch data low.
  input wire logic [15:0] arr_ra1, // Fetch index high.
  output fmc_pkg::fmc_hw_t arr_rd1, // Fetch data high.
  input wire logic [15:0] arr_ca, // Command index.
  output fmc_pkg::fmc_hw_t arr_crd, // Command data.
  input wire logic [1:0] arr_prog_ff, // Program pulses.
  input wire logic [1:0] arr_erase_ff, // Erase pulses.
  input wire logic [1:0] arr_mass_ff, // Mass pulses.
  input wire logic [31:0] arr_pa_ff, // Target indexes.
  input wire logic [31:0] arr_pd_ff // Program data.
);
  import fmc_pkg::*;
  fmc_hw_t mem [0:49151]; // 48k half-words.
  logic [15:0] ix [0:1]; // Array index per block.
  // Out-of-range reads give a pattern, never a settled unknown.
  function automatic fmc_hw_t rd(input logic [15:0] a);
    rd = (a < 16'hC000) ? mem[a] : 16'h5AA5;
  endfunction : rd
  assign arr_rd0 = rd(arr_ra0);
  assign arr_rd1 = rd(arr_ra1);
  assign arr_crd = rd(arr_ca);
  // Fresh array reads all ones.
  initial for (int i = 0; i < 49152; i++) mem[i] = 16'hFFFF;
  // Apply program, page erase and mass erase pulses per block.
  always @(posedge core_clk) begin
    ix[0] = arr_pa_ff[15:0] | 16'h8000;
    ix[1] = arr_pa_ff[31:16] & 16'h7FFF;
    for (int b = 0; b < 2; b++) begin
      if (arr_prog_ff[b]) mem[ix[b]] &= arr_pd_ff[16*b +: 16];
      if (arr_erase_ff[b]) begin
        for (int i = 0; i < 256; i++) mem[{ix[b][15:8], 8'h00} + i] = '1;
      end
      if (arr_mass_ff[b]) begin
        for (int i = 0; i < 16'hBC00; i++) begin
          if ((i >= 16'h8000) == (b == 0)) mem[i] = '1;
        end
      end
    end
  end
endmodule : fmc_array_model

// file: fmc_consts.svh
// Purpose: Offsets, command codes, field positions and timings.
// Assumes: Included by the flash memory controller module, its checker and its bench.
// Notes:   Times are in microseconds of the independent timebase.
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FMC_MMR_PAGE 24'hFFFF0E
`define FMC_OFF_STA 7'h00
`define FMC_OFF_MOD 7'h04
`define FMC_OFF_CON 7'h08
`define FMC_OFF_DAT 7'h0C
`define FMC_OFF_ADR 7'h10
`define FMC_OFF_SIGN 7'h18
`define FMC_OFF_PRO 7'h1C
`define FMC_OFF_HIDE 7'h20
`define FMC_CON_RST 8'h07
`define FMC_ALL_ONES_HW 16'hFFFF
`define FMC_HIDE_KEY 24'hA5C35A
// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FMC_CMD_READ 8'h01
`define FMC_CMD_PROG 8'h02
`define FMC_CMD_EWR 8'h03
`define FMC_CMD_VFY 8'h04
`define FMC_CMD_ERASE 8'h05
`define FMC_CMD_MASS 8'h06
`define FMC_CMD_SIGN 8'h0B
// ----------------------------------------------------------------
// Fields, address map and timings
// ----------------------------------------------------------------
`define FMC_STA_DONE 0
`define FMC_STA_FAIL 1
`define FMC_STA_BUSY 2
`define FMC_STA_ERR 3
`define FMC_MOD_WEN 3
`define FMC_HIDE_WEN 0
`define FMC_PHYS_BASE 32'h00080000
`define FMC_SPAN 32'h00018000
`define FMC_BLK0_OFS 17'h10000
`define FMC_KERN_OFS 17'h17800
`define FMC_KERN_ADR 15'h7800
`define FMC_PROG_US 50
`define FMC_ERASE_US 20000
`define FMC_MASS_US 1200000
`endif

// file: fmc_flash_ctrl.sv
// Purpose: Two-block flash controller: fetch path and command sequencer.
// Assumes: Array reads are combinational; timebase toggles once a us.
// Notes:   Block 1 is index 0x0000-0x7FFF, block 0 is 0x8000-0xBFFF.
// Operation
// - Array is 48k half-words of 16 bits.
// - Page erase works on 512-byte pages; mass erase clears a whole block, bar the top 2KB kernel of block 0.
// - Page erase takes 20 ms.
// - Half-word program takes 50 us.
// - Op timing uses core-independent timebase.
// - Word fetch reads two half-words together.
// - Array at 0x80000, aliased at zero after reset.
// - Erased locations read all ones.
// - Read 8/16/32 bits, program 16 bits.
// - Block 0 at 0x90000, top 2KB kernel.
// - Block 1 at 0x80000, own registers.
// - Other block keeps serving while one busy.
// - Access to busy block stalls the core.
// - Read-only status register per block.
// - 8-bit command register starts operations.
// - 16-bit data register per block.
// - 16-bit address register per block.
// - Signature command loads 24-bit signature.
// - Protection register, keyed once configured.
// - Protection shadow loads on every reset.
// - Command codes 0x01 to 0x06 and 0x0B as listed.
// - Verify result goes to status bit 1.
`timescale 1ns/1ns
`include "fmc_consts.svh"
module fmc_flash_ctrl #(
  parameter int PROG_US = `FMC_PROG_US,
  parameter int ERASE_US = `FMC_ERASE_US,
  parameter int MASS_US = `FMC_MASS_US
) (
  input wire logic core_clk, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic tb_toggle, // Timebase pin, toggles each us.
  input wire logic sram_at_zero, // High when SRAM owns address zero.
  input wire logic cpu_req, // Core read or fetch request.
  input wire logic [31:0] cpu_addr, // Core byte address.
  input wire logic [1:0] cpu_size, // 0 byte, 1 half-word, 2 word.
  output logic cpu_hit, // Address falls in the array.
  output logic cpu_stall, // Core must hold its request.
  output logic cpu_ack_ff, // Read data valid.
  output logic [31:0] cpu_rdata_ff, // Read data, low-justified.
  input wire logic mmr_wr, // Register write strobe.
  input wire logic mmr_rd, // Register read strobe.
  input wire logic [31:0] mmr_addr, // Register byte address.
  input wire logic [31:0] mmr_wdata, // Register write data.
  output logic [31:0] mmr_rdata_ff, // Register read data.
  output logic [15:0] arr_ra0, // Fetch read index, low half.
  input wire fmc_pkg::fmc_hw_t arr_rd0, // Fetch read data, low half.
  output logic [15:0] arr_ra1, // Fetch read index, high half.
  input wire fmc_pkg::fmc_hw_t arr_rd1, // Fetch read data, high half.
  output logic [15:0] arr_ca, // Command read index.
  input wire fmc_pkg::fmc_hw_t arr_crd, // Command read data.
  output logic [1:0] arr_prog_ff, // Program pulse, one bit per block.
  output logic [1:0] arr_erase_ff, // Page erase pulse per block.
  output logic [1:0] arr_mass_ff, // Mass erase pulse per block.
  output logic [31:0] arr_pa_ff, // Target index, block 1 high.
  output logic [31:0] arr_pd_ff, // Program data, block 1 high.
  input wire logic [7:0] prot_shadow0, // Stored protection, block 0.
  input wire logic [7:0] prot_shadow1 // Stored protection, block 1.
);
  import fmc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Maps a block and its 16-bit byte address to a half-word index.
  function automatic logic [15:0] fmc_idx(input logic b,
                                          input logic [15:0] a);
    fmc_idx = b ? {1'b0, a[15:1]} : {2'b10, a[14:1]};
  endfunction : fmc_idx

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fmc_state_t state_ff [2]; // Sequencer state per block.
  logic [7:0] cmd_ff [2]; // Last accepted command.
  logic [7:0] mod_ff [2]; // Mode register.
  logic [15:0] dat_ff [2]; // Data register.
  logic [15:0] adr_ff [2]; // Address register.
  logic [23:0] sign_ff [2]; // Signature register.
  logic [7:0] hide_ff [2]; // Protection register.
  logic [20:0] tmr_ff [2]; // Remaining microseconds.
  logic [7:0] walk_ff [2]; // Signature walk position.
  logic done_ff [2]; // Command finished.
  logic fail_ff [2]; // Verify mismatch.
  logic err_ff [2]; // Command refused.
  logic tb_s1_ff, tb_s2_ff, tb_s3_ff; // Timebase synchroniser.
  logic tb_lvl_ff; // Last accepted timebase level.
  logic us_tick; // One pulse per timebase edge.
  logic reg_hit; // Access falls in the register page.
  logic wblk; // Register block selected, 1 or 0.
  logic [6:0] woff; // Register offset inside the block.
  logic cmd_go; // Command register write.
  logic key_ok; // Protection write is allowed.
  logic [7:0] shadow [2]; // Shadow inputs as an array.
  logic sign_any; // A signature walk is running.
  logic sblk; // Block doing the signature walk.
  logic [31:0] pa; // Physical core address.
  logic [16:0] ofs; // Offset inside the array.
  logic cblk; // Block of the core access.
  logic [31:0] word; // Fetched word.
  logic [31:0] lane; // Selected lanes.

  assign shadow[0] = prot_shadow0;
  assign shadow[1] = prot_shadow1;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------

  // Brings the oscillator toggle in; a change counts once s2 and s3
  // agree, so the op time never depends on the core clock.
  always_ff @(posedge core_clk) begin
    tb_s1_ff <= tb_toggle;
    tb_s2_ff <= tb_s1_ff;
    tb_s3_ff <= tb_s2_ff;
    // Reset takes the present level, so no false edge follows it.
    if (rst || tb_s2_ff == tb_s3_ff) begin
      tb_lvl_ff <= tb_s3_ff;
    end
  end

  // A new agreed level marks one microsecond.
  assign us_tick = (tb_s2_ff == tb_s3_ff) &&
                   (tb_s3_ff != tb_lvl_ff);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Register page decode; bit 7 picks block 0 (low) or block 1.
  assign reg_hit = (mmr_addr[31:8] == `FMC_MMR_PAGE);
  assign wblk = mmr_addr[7];
  assign woff = mmr_addr[6:0];
  assign cmd_go = mmr_wr && reg_hit && (woff == `FMC_OFF_CON);
  // Protection changes need the key once the shadow is set.
  assign key_ok = (shadow[wblk] == 8'hFF) ||
                  (mmr_wdata[31:8] == `FMC_HIDE_KEY);
  assign sign_any = (state_ff[0] == FMC_SIGN) || (state_ff[1] == FMC_SIGN);
  assign sblk = (state_ff[1] == FMC_SIGN);

  // Array at its physical place, or aliased at zero.
  always_comb begin
    pa = cpu_addr;
    if (!sram_at_zero && cpu_addr < `FMC_SPAN) begin
      pa = cpu_addr + `FMC_PHYS_BASE;
    end
  end

  // Block 1 below 0x90000, block 0 above it.
  assign ofs = 17'(pa - `FMC_PHYS_BASE);
  assign cpu_hit = (pa >= `FMC_PHYS_BASE) &&
                   (pa < `FMC_PHYS_BASE + `FMC_SPAN);
  assign cblk = (ofs < `FMC_BLK0_OFS);

  // Both halves of a word are read in the same cycle.
  assign arr_ra0 = {ofs[16:2], 1'b0};
  assign arr_ra1 = {ofs[16:2], 1'b1};
  // Kernel space reads back as erased ones.
  assign word = (ofs >= `FMC_KERN_OFS) ?
                {`FMC_ALL_ONES_HW, `FMC_ALL_ONES_HW} : {arr_rd1, arr_rd0};

  // Picks the byte or half-word lane, little endian.
  always_comb begin
    unique case (cpu_size)
      2'd0: lane = {24'h000000, word[8*cpu_addr[1:0] +: 8]};
      2'd1: lane = {16'h0000, word[16*cpu_addr[1] +: 16]};
      default: lane = word;
    endcase
  end

  // Only the busy block stalls; the other keeps serving.
  assign cpu_stall = cpu_req && cpu_hit &&
                     (state_ff[cblk] != FMC_IDLE);

  // Command reads use the signature walk or the addressed block.
  assign arr_ca = sign_any ?
                  fmc_idx(sblk, {adr_ff[sblk][15:9], walk_ff[sblk], 1'b0}) :
                  fmc_idx(wblk, adr_ff[wblk]);

  // ----------------------------------------------------------------
  // Core read port
  // ----------------------------------------------------------------

  // Registers fetched data one cycle after an unstalled request.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_ack_ff <= 1'b0;
      cpu_rdata_ff <= 32'h00000000;
    end else begin
      cpu_ack_ff <= cpu_req && cpu_hit && !cpu_stall;
      if (cpu_req && cpu_hit && !cpu_stall) begin
        cpu_rdata_ff <= lane;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  // Returns the addressed register one cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mmr_rdata_ff <= 32'h00000000;
    end else if (mmr_rd) begin
      mmr_rdata_ff <= 32'h00000000;
      if (reg_hit) begin
        unique case (woff)
          `FMC_OFF_STA: mmr_rdata_ff <= {28'h0000000, err_ff[wblk],
                        state_ff[wblk] != FMC_IDLE, fail_ff[wblk],
                        done_ff[wblk]};
          `FMC_OFF_MOD: mmr_rdata_ff <= {24'h000000, mod_ff[wblk]};
          `FMC_OFF_CON: mmr_rdata_ff <= {24'h000000, cmd_ff[wblk]};
          `FMC_OFF_DAT: mmr_rdata_ff <= {16'h0000, dat_ff[wblk]};
          `FMC_OFF_ADR: mmr_rdata_ff <= {16'h0000, adr_ff[wblk]};
          `FMC_OFF_SIGN: mmr_rdata_ff <= {8'h00, sign_ff[wblk]};
          `FMC_OFF_PRO: mmr_rdata_ff <= {24'h000000, shadow[wblk]};
          `FMC_OFF_HIDE: mmr_rdata_ff <= {24'h000000, hide_ff[wblk]};
          default: mmr_rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencers, one per block
  // ----------------------------------------------------------------

  // Registers, command start, timed wait and signature walk.
  always_ff @(posedge core_clk) begin
    for (int b = 0; b < 2; b++) begin
      if (rst) begin
        state_ff[b] <= FMC_IDLE;
        cmd_ff[b] <= `FMC_CON_RST;
        mod_ff[b] <= 8'h00;
        dat_ff[b] <= 16'h0000;
        adr_ff[b] <= 16'h0000;
        sign_ff[b] <= 24'h000000;
        hide_ff[b] <= shadow[b];
        tmr_ff[b] <= 21'h000000;
        walk_ff[b] <= 8'h00;
        done_ff[b] <= 1'b0;
        fail_ff[b] <= 1'b0;
        err_ff[b] <= 1'b0;
        arr_prog_ff[b] <= 1'b0;
        arr_erase_ff[b] <= 1'b0;
        arr_mass_ff[b] <= 1'b0;
        arr_pa_ff[16*b +: 16] <= 16'h0000;
        arr_pd_ff[16*b +: 16] <= 16'h0000;
      end else begin
        arr_prog_ff[b] <= 1'b0;
        arr_erase_ff[b] <= 1'b0;
        arr_mass_ff[b] <= 1'b0;
        // Plain register writes.
        if (mmr_wr && reg_hit && wblk == b[0]) begin
          unique case (woff)
            `FMC_OFF_MOD: mod_ff[b] <= mmr_wdata[7:0];
            `FMC_OFF_DAT: dat_ff[b] <= mmr_wdata[15:0];
            `FMC_OFF_ADR: adr_ff[b] <= mmr_wdata[15:0];
            `FMC_OFF_HIDE: begin
              if (key_ok) begin
                hide_ff[b] <= mmr_wdata[7:0];
              end
            end
            default: ;
          endcase
        end
        if (cmd_go && wblk == b[0]) begin
          // A new command clears the old done and error flags first.
          done_ff[b] <= 1'b0;
          err_ff[b] <= 1'b0;
          if (state_ff[b] != FMC_IDLE || sign_any) begin
            err_ff[b] <= 1'b1; // Refused while a walk or op runs.
          end else begin
            cmd_ff[b] <= mmr_wdata[7:0];
            unique case (mmr_wdata[7:0])
              `FMC_CMD_READ: begin
                dat_ff[b] <= arr_crd;
                done_ff[b] <= 1'b1;
              end
              `FMC_CMD_VFY: begin
                fail_ff[b] <= (arr_crd != dat_ff[b]);
                done_ff[b] <= 1'b1;
              end
              `FMC_CMD_PROG, `FMC_CMD_EWR, `FMC_CMD_ERASE,
              `FMC_CMD_MASS: begin
                // Writes need mode and protection enables and stay
                // out of the kernel space.
                if (!mod_ff[b][`FMC_MOD_WEN] ||
                    !hide_ff[b][`FMC_HIDE_WEN] ||
                    (b == 0 && adr_ff[b][14:0] >= `FMC_KERN_ADR &&
                     mmr_wdata[7:0] != `FMC_CMD_MASS)) begin
                  err_ff[b] <= 1'b1;
                end else begin
                  state_ff[b] <= FMC_WAIT;
                  // Program is whole half-words only.
                  arr_pa_ff[16*b +: 16] <= fmc_idx(b[0], adr_ff[b]);
                  arr_pd_ff[16*b +: 16] <= dat_ff[b];
                  unique case (mmr_wdata[7:0])
                    `FMC_CMD_PROG: begin
                      arr_prog_ff[b] <= 1'b1;
                      tmr_ff[b] <= 21'(PROG_US);
                    end
                    `FMC_CMD_MASS: begin
                      arr_mass_ff[b] <= 1'b1;
                      tmr_ff[b] <= 21'(MASS_US);
                    end
                    default: begin
                      // Page erase leaves the page all ones.
                      arr_pa_ff[16*b +: 16] <= fmc_idx(b[0],
                        {adr_ff[b][15:9], 9'h000});
                      arr_erase_ff[b] <= 1'b1;
                      tmr_ff[b] <= 21'(ERASE_US);
                    end
                  endcase
                end
              end
              `FMC_CMD_SIGN: begin
                state_ff[b] <= FMC_SIGN;
                walk_ff[b] <= 8'h00;
                sign_ff[b] <= 24'h000000;
              end
              default: ;
            endcase
          end
        end
        // A refused command neither stalls the timer nor the walk.
        if (state_ff[b] == FMC_WAIT && us_tick) begin
          // Counts microseconds of the timebase.
          tmr_ff[b] <= tmr_ff[b] - 21'd1;
          if (tmr_ff[b] == 21'd1) begin
            state_ff[b] <= FMC_IDLE;
            done_ff[b] <= 1'b1;
            // Erase-then-program writes its half-word after the erase.
            if (cmd_ff[b] == `FMC_CMD_EWR) begin
              arr_pa_ff[16*b +: 16] <= fmc_idx(b[0], adr_ff[b]);
              arr_prog_ff[b] <= 1'b1;
            end
          end
        end else if (state_ff[b] == FMC_SIGN) begin
          // Folds each half-word of the page into the signature.
          sign_ff[b] <= {sign_ff[b][22:0], sign_ff[b][23]} ^
                        {8'h00, arr_crd};
          walk_ff[b] <= walk_ff[b] + 8'd1;
          if (walk_ff[b] == 8'hFF) begin
            state_ff[b] <= FMC_IDLE;
            done_ff[b] <= 1'b1;
          end
        end
      end
    end
  end
endmodule : fmc_flash_ctrl

// file: fmc_flash_ctrl_checker.sv
// Purpose: Port-level assertions for the flash memory controller.
// Assumes: Bound to fmc_flash_ctrl; one clock domain.
// Notes:   Block 1 is 0x80000-0x8FFFF, block 0 is 0x90000-0x97FFF.
`timescale 1ns/1ns
`include "fmc_consts.svh"
module fmc_flash_ctrl_checker (
  input wire logic core_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic sram_at_zero, // Alias off.
  input wire logic cpu_req, // Core request.
  input wire logic [31:0] cpu_addr, // Core address.
  input wire logic [1:0] cpu_size, // Core size.
  input wire logic cpu_hit, // Array hit.
  input wire logic cpu_stall, // Core stall.
  input wire logic cpu_ack_ff, // Data valid.
  input wire logic mmr_wr, // Register write.
  input wire logic [31:0] mmr_addr, // Register address.
  input wire logic [31:0] mmr_wdata, // Register data.
  input wire logic [15:0] arr_ra0, // Low index.
  input wire logic [15:0] arr_ra1, // High index.
  input wire logic [1:0] arr_prog_ff, // Program pulses.
  input wire logic [1:0] arr_erase_ff, // Erase pulses.
  input wire logic [1:0] arr_mass_ff, // Mass pulses.
  input wire logic [31:0] arr_pa_ff // Target indexes.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A core read that the controller takes.
  sequence s_take;
    cpu_req && cpu_hit && !cpu_stall;
  endsequence
  // Block 1 starts a program from its command write, then the core
  // asks for block 1.
  sequence s_prog_start;
    arr_prog_ff[1] && $past(mmr_wr && mmr_addr == 32'hFFFF0E88) ##1
      (cpu_req && cpu_addr[31:16] == 16'h0008);
  endsequence
  a_ack_next: assert property (s_take |=> cpu_ack_ff)
    else $error("read not answered next cycle");
  a_ack_cause: assert property (cpu_ack_ff |->
    $past(cpu_req && cpu_hit && !cpu_stall))
    else $error("answer without request");
  a_word_pair: assert property (cpu_req && cpu_size == 2'd2 &&
    cpu_addr[1:0] == 2'b00 && cpu_addr[31:16] == 16'h0008 |->
    arr_ra0 == {1'b0, cpu_addr[15:1]} && arr_ra1 == arr_ra0 + 16'd1)
    else $error("word fetch indexes wrong");
  a_phys_hit: assert property (cpu_addr >= 32'h80000 &&
    cpu_addr <= 32'h97FFF |-> cpu_hit)
    else $error("array address missed");
  a_alias_map: assert property (cpu_addr < 32'h18000 |->
    cpu_hit == !sram_at_zero)
    else $error("alias at zero wrong");
  a_stall_busy: assert property (s_prog_start |-> cpu_stall)
    else $error("busy block not stalled");
  a_prog_spacing: assert property (arr_prog_ff[1] |=>
    (!arr_prog_ff[1])[*8])
    else $error("program pulses too close");
  a_erase_page: assert property (arr_erase_ff[1] |->
    arr_pa_ff[23:16] == 8'h00)
    else $error("erase not page aligned");
  a_erase_cause: assert property (arr_erase_ff[1] |-> $past(mmr_wr &&
    mmr_addr == 32'hFFFF0E88 && mmr_wdata[7:0] inside
    {`FMC_CMD_EWR, `FMC_CMD_ERASE}))
    else $error("erase without command");
  a_mass_cause: assert property (arr_mass_ff[1] |->
    $past(mmr_wr && mmr_wdata[7:0] == `FMC_CMD_MASS))
    else $error("mass erase without command");
endmodule : fmc_flash_ctrl_checker
bind fmc_flash_ctrl fmc_flash_ctrl_checker u_chk (.core_clk(core_clk),
  .rst(rst), .sram_at_zero(sram_at_zero), .cpu_req(cpu_req),
  .cpu_addr(cpu_addr), .cpu_size(cpu_size), .cpu_hit(cpu_hit),
  .cpu_stall(cpu_stall), .cpu_ack_ff(cpu_ack_ff), .mmr_wr(mmr_wr),
  .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata), .arr_ra0(arr_ra0),
  .arr_ra1(arr_ra1), .arr_prog_ff(arr_prog_ff),
  .arr_erase_ff(arr_erase_ff), .arr_mass_ff(arr_mass_ff),
  .arr_pa_ff(arr_pa_ff));

// file: fmc_pkg.sv
// Purpose: Types shared by the flash memory controller.
// Assumes: Constants live in fmc_consts.svh.
// Notes:   Types only.
package fmc_pkg;
  typedef logic [15:0] fmc_hw_t; // One array half-word.
  typedef enum logic [1:0] {FMC_IDLE, FMC_WAIT, FMC_SIGN} fmc_state_t;
endpackage : fmc_pkg
